// >>> pcsd_pkg.sv
// Package with register map, field layout, reset values and shared types of the clock block.
// Notes on behaviour
// - While the loop drives the root clock it keeps running in wait and stop.
// - Loop output equals phase-detector base frequency times the 12-bit loop count.
// - The 12-bit reference count divides the crystal input to feed the detector.
// - Reset loads both divide counts with their maximum value.
// - Lock indicator reads 1 only while loop frequency is within half and twice target.
// - Writing 1 to loop power-on enables the loop; writing 0 disables it.
// - Loop output becomes root clock only when selected and locked; else crystal.
// - System clock is root clock divided by two to the base select value.
// - Bus-rate clock is the system clock halved.
// - Module timebase is bus-rate clock divided by 1, 2, 4 or 8.
// - Module timebase feeds baud generators, timer counter, periodic interrupt and watchdog.
// - One write to the control register updates base and module selects together.
// - Every divider and control register can be read and written at any time, except the read-only lock indicator bit.
package pcsd_pkg;

  // ==========================================================================
  // Register map, byte addresses of aligned words.
  localparam logic [7:0] PCSD_OFS_LOOP_HI = 8'h00;
  localparam logic [7:0] PCSD_OFS_LOOP_LO = 8'h04;
  localparam logic [7:0] PCSD_OFS_REF_HI = 8'h08;
  localparam logic [7:0] PCSD_OFS_REF_LO = 8'h0c;
  localparam logic [7:0] PCSD_OFS_CTL = 8'h10;

  // ==========================================================================
  // Reset values and the fixed bus divide select.
  localparam logic [11:0] PCSD_DIV_RST = 12'hfff;
  localparam logic PCSD_ON_RST = 1'b0;
  localparam logic PCSD_SEL_RST = 1'b0;
  localparam logic [2:0] PCSD_BCS_RST = 3'h0;
  localparam logic [1:0] PCSD_MCS_RST = 2'h0;
  localparam logic [2:0] PCSD_BUS_HALF = 3'h1;

  // ==========================================================================
  // AHB transfer type of a valid request has bit 1 set.
  localparam int PCSD_HTRANS_VALID_BIT = 1;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic lock_indicator;
    logic loop_power_on;
    logic loop_output_select;
    logic [2:0] base_divide_select;
    logic [1:0] module_divide_select;
  } pcsd_ctl_s;

  typedef enum logic [2:0] {
    PCSD_R_LOOP_HI = 3'h0,
    PCSD_R_LOOP_LO = 3'h1,
    PCSD_R_REF_HI = 3'h2,
    PCSD_R_REF_LO = 3'h3,
    PCSD_R_CTL = 3'h4,
    PCSD_R_NONE = 3'h7
  } pcsd_reg_e;

  // Gray path: off, acquiring, locked.
  typedef enum logic [1:0] {
    PCSD_LOOP_OFF = 2'b00,
    PCSD_LOOP_ACQ = 2'b01,
    PCSD_LOOP_LOCK = 2'b11
  } pcsd_loop_e;

  // Low bits that must all be set for a divide by two to the select.
  function automatic logic [6:0] pcsd_mask(input logic [2:0] sel);
    pcsd_mask = 7'(({1'b0, 7'h7f} >> (3'h7 - sel)) & 8'h7f);
  endfunction

  function automatic pcsd_reg_e pcsd_decode(input logic [7:0] ofs);
    case (ofs)
      PCSD_OFS_LOOP_HI: pcsd_decode = PCSD_R_LOOP_HI;
      PCSD_OFS_LOOP_LO: pcsd_decode = PCSD_R_LOOP_LO;
      PCSD_OFS_REF_HI: pcsd_decode = PCSD_R_REF_HI;
      PCSD_OFS_REF_LO: pcsd_decode = PCSD_R_REF_LO;
      PCSD_OFS_CTL: pcsd_decode = PCSD_R_CTL;
      default: pcsd_decode = PCSD_R_NONE;
    endcase
  endfunction

endpackage

// >>> pcsd_pow2_div.sv
// Power-of-two enable divider that takes a new ratio only at a period boundary.
`timescale 1ns/1ps
module pcsd_pow2_div
  import pcsd_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Rate in and out
  input wire logic en_in,
  input wire logic [2:0] sel,
  output logic en_out
);

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [2:0] sel_r;
  logic [2:0] sel_nxt;
  logic term;

  assign term = (cnt_r & pcsd_mask(sel_r)) == pcsd_mask(sel_r);
  assign en_out = en_in && term;

  // A new ratio waits for the end of the running period, so no short period appears.
  always_comb begin
    cnt_nxt = cnt_r;
    sel_nxt = sel_r;
    if (en_in) begin
      cnt_nxt = term ? 7'h00 : 7'(cnt_r + 7'h01);
      if (term) begin
        sel_nxt = sel;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 7'h00;
      sel_r <= 3'h0;
    end else begin
      cnt_r <= cnt_nxt;
      sel_r <= sel_nxt;
    end
  end

  property p_out_at_term;
    @(posedge hclk) disable iff (!hresetn)
    en_out |-> en_in && ((cnt_r & pcsd_mask(sel_r)) == pcsd_mask(sel_r));
  endproperty
  a_out_at_term: assert property (p_out_at_term) else $error("divider pulsed off boundary");

endmodule

// >>> pcsd_clock_ctrl.sv
// Loop model, root clock select and divider chain with an AHB-Lite register slave.
`timescale 1ns/1ps
module pcsd_clock_ctrl
  import pcsd_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Low-power state of the core
  input wire logic wait_mode,
  input wire logic stop_mode,
  // Clock enables and status
  output logic sys_clk_en,
  output logic bus_clk_en,
  output logic mod_clk_en,
  output logic baud_tick,
  output logic timer_tick,
  output logic rti_tick,
  output logic cop_tick,
  output logic loop_running,
  output logic root_is_loop
);

  // ==========================================================================
  // Registers and bus slave.
  logic [11:0] loop_div_r;
  logic [11:0] loop_div_nxt;
  logic [11:0] ref_div_r;
  logic [11:0] ref_div_nxt;
  pcsd_ctl_s ctl_r;
  pcsd_ctl_s ctl_nxt;
  logic wr_pend_r;
  logic wr_pend_nxt;
  pcsd_reg_e idx_r;
  pcsd_reg_e idx_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic req;
  pcsd_reg_e req_idx;
  pcsd_loop_e loop_st_r;
  pcsd_loop_e loop_st_nxt;

  assign req = hsel && htrans[PCSD_HTRANS_VALID_BIT] && hready;
  assign req_idx = pcsd_decode(haddr[7:0]);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  // Writes land in the data phase; reads sample the post-write values, so a read
  // right after a write to the same register already sees the new value.
  always_comb begin
    loop_div_nxt = loop_div_r;
    ref_div_nxt = ref_div_r;
    ctl_nxt = ctl_r;
    ctl_nxt.lock_indicator = 1'b0;
    if (wr_pend_r) begin
      case (idx_r)
        PCSD_R_LOOP_HI: loop_div_nxt[11:8] = hwdata[3:0];
        PCSD_R_LOOP_LO: loop_div_nxt[7:0] = hwdata[7:0];
        PCSD_R_REF_HI: ref_div_nxt[11:8] = hwdata[3:0];
        PCSD_R_REF_LO: ref_div_nxt[7:0] = hwdata[7:0];
        PCSD_R_CTL: begin
          ctl_nxt = pcsd_ctl_s'(hwdata[7:0]);
          ctl_nxt.lock_indicator = 1'b0;
        end
        default: ctl_nxt = ctl_r;
      endcase
    end
    wr_pend_nxt = req && hwrite;
    idx_nxt = req ? req_idx : idx_r;
    rdata_nxt = rdata_r;
    if (req && !hwrite) begin
      case (req_idx)
        PCSD_R_LOOP_HI: rdata_nxt = {28'h0000000, loop_div_nxt[11:8]};
        PCSD_R_LOOP_LO: rdata_nxt = {24'h000000, loop_div_nxt[7:0]};
        PCSD_R_REF_HI: rdata_nxt = {28'h0000000, ref_div_nxt[11:8]};
        PCSD_R_REF_LO: rdata_nxt = {24'h000000, ref_div_nxt[7:0]};
        PCSD_R_CTL: begin
          rdata_nxt = {24'h000000, ctl_nxt};
          rdata_nxt[7] = (loop_st_r == PCSD_LOOP_LOCK);
        end
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop_div_r <= PCSD_DIV_RST;
      ref_div_r <= PCSD_DIV_RST;
      ctl_r <= '{1'b0, PCSD_ON_RST, PCSD_SEL_RST, PCSD_BCS_RST, PCSD_MCS_RST};
      wr_pend_r <= 1'b0;
      idx_r <= PCSD_R_NONE;
      rdata_r <= 32'h00000000;
    end else begin
      loop_div_r <= loop_div_nxt;
      ref_div_r <= ref_div_nxt;
      ctl_r <= ctl_nxt;
      wr_pend_r <= wr_pend_nxt;
      idx_r <= idx_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Loop model: reference divider, slewing multiplier, lock state.
  // The analog loop is replaced by a multiplier that moves halfway to its target
  // on each phase-detector event; it locks after the first event and settles within a dozen reference periods.
  logic [11:0] ref_cnt_r;
  logic [11:0] ref_cnt_nxt;
  logic [11:0] mult_r;
  logic [11:0] mult_nxt;
  logic [11:0] ref_eff;
  logic ref_tick;
  logic run;
  logic in_range;
  logic locked;
  logic use_loop_r;
  logic [12:0] step;

  assign ref_eff = (ref_div_r == 12'h000) ? 12'h001 : ref_div_r;
  assign ref_tick = run && (ref_cnt_r >= 12'(ref_eff - 12'h001));
  // Selected loop ignores stop and wait; an unselected one halts in stop.
  assign run = ctl_r.loop_power_on && (!stop_mode || use_loop_r);
  assign in_range = ({mult_r, 1'b0} >= {1'b0, loop_div_r}) && ({1'b0, mult_r} <= {loop_div_r, 1'b0});
  assign locked = (loop_st_r == PCSD_LOOP_LOCK);

  always_comb begin
    ref_cnt_nxt = ref_cnt_r;
    mult_nxt = mult_r;
    step = 13'h0000;
    loop_st_nxt = loop_st_r;
    if (!run) begin
      ref_cnt_nxt = 12'h000;
      mult_nxt = 12'h000;
      loop_st_nxt = PCSD_LOOP_OFF;
    end else begin
      ref_cnt_nxt = ref_tick ? 12'h000 : 12'(ref_cnt_r + 12'h001);
      if (ref_tick && (mult_r < loop_div_r)) begin
        step = 13'(({1'b0, loop_div_r} - {1'b0, mult_r} + 13'h0001) >> 1);
        mult_nxt = 12'(mult_r + step[11:0]);
      end else if (ref_tick && (mult_r > loop_div_r)) begin
        step = 13'(({1'b0, mult_r} - {1'b0, loop_div_r} + 13'h0001) >> 1);
        mult_nxt = 12'(mult_r - step[11:0]);
      end
      case (loop_st_r)
        PCSD_LOOP_OFF: loop_st_nxt = PCSD_LOOP_ACQ;
        PCSD_LOOP_ACQ: loop_st_nxt = in_range ? PCSD_LOOP_LOCK : PCSD_LOOP_ACQ;
        PCSD_LOOP_LOCK: loop_st_nxt = in_range ? PCSD_LOOP_LOCK : PCSD_LOOP_ACQ;
        default: loop_st_nxt = PCSD_LOOP_OFF;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt_r <= 12'h000;
      mult_r <= 12'h000;
      loop_st_r <= PCSD_LOOP_OFF;
    end else begin
      ref_cnt_r <= ref_cnt_nxt;
      mult_r <= mult_nxt;
      loop_st_r <= loop_st_nxt;
    end
  end

  // ==========================================================================
  // Loop output as a rate: mult / ref events per crystal cycle.
  // The rate saturates at one event per crystal cycle; settings above the crystal
  // rate cannot be shown and must be avoided by software anyway.
  logic [12:0] acc_r;
  logic [12:0] acc_nxt;
  logic [13:0] sum;
  logic [13:0] rem;
  logic loop_tick;

  always_comb begin
    sum = 14'({1'b0, acc_r} + {2'b00, mult_r});
    loop_tick = run && (sum >= {2'b00, ref_eff});
    rem = loop_tick ? 14'(sum - {2'b00, ref_eff}) : sum;
    if (rem >= {2'b00, ref_eff}) begin
      rem = 14'({2'b00, ref_eff} - 14'h0001);
    end
    acc_nxt = run ? rem[12:0] : 13'h0000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= 13'h0000;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // ==========================================================================
  // Root select and divider chain.
  logic use_loop_nxt;
  logic root_en;
  logic sys_en;
  logic bus_en;
  logic mod_en;
  logic sys_clk_en_r;
  logic bus_clk_en_r;
  logic mod_clk_en_r;

  // Switch only at a system clock boundary; a lost lock falls back at once,
  // since the loop events that would mark the boundary may have stopped.
  always_comb begin
    use_loop_nxt = use_loop_r;
    if (sys_en || (use_loop_r && !locked)) begin
      use_loop_nxt = ctl_r.loop_output_select && locked;
    end
  end

  assign root_en = use_loop_r ? loop_tick : 1'b1;

  pcsd_pow2_div u_sys_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .en_in(root_en),
    .sel(ctl_r.base_divide_select),
    .en_out(sys_en)
  );

  pcsd_pow2_div u_bus_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .en_in(sys_en),
    .sel(PCSD_BUS_HALF),
    .en_out(bus_en)
  );

  pcsd_pow2_div u_mod_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .en_in(bus_en),
    .sel({1'b0, ctl_r.module_divide_select}),
    .en_out(mod_en)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      use_loop_r <= 1'b0;
      sys_clk_en_r <= 1'b0;
      bus_clk_en_r <= 1'b0;
      mod_clk_en_r <= 1'b0;
    end else begin
      use_loop_r <= use_loop_nxt;
      sys_clk_en_r <= sys_en;
      bus_clk_en_r <= bus_en;
      mod_clk_en_r <= mod_en;
    end
  end

  assign sys_clk_en = sys_clk_en_r;
  assign bus_clk_en = bus_clk_en_r;
  assign mod_clk_en = mod_clk_en_r;
  assign baud_tick = mod_clk_en_r;
  assign timer_tick = mod_clk_en_r;
  assign rti_tick = mod_clk_en_r;
  assign cop_tick = mod_clk_en_r;
  assign loop_running = run;
  assign root_is_loop = use_loop_r;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_keep_running;
    (ctl_r.loop_power_on && use_loop_r && (stop_mode || wait_mode)) |-> run;
  endproperty
  a_keep_running: assert property (p_keep_running) else $error("selected loop halted");

  // A shortened count may tick late once, so only the full count is held to an exact tick.
  property p_ref_period;
    (run && (ref_cnt_r == 12'(ref_eff - 12'h001))) |-> ref_tick ##1 (ref_cnt_r == 12'h000);
  endproperty
  a_ref_period: assert property (p_ref_period) else $error("reference tick off count");

  property p_lock_range;
    $rose(locked) |-> $past(in_range);
  endproperty
  a_lock_range: assert property (p_lock_range) else $error("lock set out of range");

  property p_off;
    (!ctl_r.loop_power_on) |=> loop_st_r == PCSD_LOOP_OFF;
  endproperty
  a_off: assert property (p_off) else $error("loop not off");

  property p_sel_lock;
    $rose(use_loop_r) |-> $past(locked) && $past(ctl_r.loop_output_select) && $past(sys_en);
  endproperty
  a_sel_lock: assert property (p_sel_lock) else $error("loop selected without lock");

  property p_sys_root;
    sys_en |-> root_en;
  endproperty
  a_sys_root: assert property (p_sys_root) else $error("system tick without root tick");

  // Parity of system ticks: each bus tick must land on every second system tick.
  logic sys_odd_r;
  logic sys_odd_nxt;

  always_comb begin
    sys_odd_nxt = sys_odd_r;
    if (sys_en) begin
      sys_odd_nxt = bus_en;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_odd_r <= 1'b0;
    end else begin
      sys_odd_r <= sys_odd_nxt;
    end
  end

  property p_bus_two;
    (sys_en || bus_en) |-> sys_en && (bus_en == !sys_odd_r);
  endproperty
  a_bus_two: assert property (p_bus_two) else $error("bus rate not half");

  property p_mod_bus;
    mod_en |-> bus_en;
  endproperty
  a_mod_bus: assert property (p_mod_bus) else $error("module tick without bus tick");

  property p_one_write;
    (wr_pend_r && idx_r == PCSD_R_CTL) |=>
      ctl_r.base_divide_select == $past(hwdata[4:2]) && ctl_r.module_divide_select == $past(hwdata[1:0]);
  endproperty
  a_one_write: assert property (p_one_write) else $error("selects not updated together");

  property p_ready;
    hreadyout && !hresp;
  endproperty
  a_ready: assert property (p_ready) else $error("bus not ready");

  c_lock: cover property ($rose(locked));
  c_switch: cover property ($rose(use_loop_r));
  c_ctl_write: cover property (wr_pend_r && idx_r == PCSD_R_CTL);
  c_mod_tick: cover property (mod_en && ctl_r.module_divide_select == 2'h3);

endmodule

// >>> pcsd_clock_ctrl_tb.sv
// Self-checking testbench of the clock control block over AHB-Lite.
`timescale 1ns/1ps
module pcsd_clock_ctrl_tb;
  import pcsd_pkg::*;

  // ==========================================================================
  // Signals
  typedef struct {logic [7:0] ctl; int n_sys; int n_bus; int n_mod;} pcsd_row_s;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic sys_clk_en, bus_clk_en, mod_clk_en, baud_tick, timer_tick, rti_tick, cop_tick;
  logic loop_running, root_is_loop;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  int s, b, m, k;
  pcsd_row_s rows [8];

  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;

  pcsd_clock_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .sys_clk_en(sys_clk_en), .bus_clk_en(bus_clk_en), .mod_clk_en(mod_clk_en), .baud_tick(baud_tick),
    .timer_tick(timer_tick), .rti_tick(rti_tick), .cop_tick(cop_tick), .loop_running(loop_running),
    .root_is_loop(root_is_loop));

  // ==========================================================================
  // Checking and closing
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hang in any wait below ends the run here; the ceiling covers the longest sequence.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      summarize();
    end
  end

  // ==========================================================================
  // Bus master tasks
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    check("response", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, d, unused);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(name, exp, r);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  task automatic chk_reset();
    rd_chk("loop hi", PCSD_OFS_LOOP_HI, 32'h0000000f);
    rd_chk("loop lo", PCSD_OFS_LOOP_LO, 32'h000000ff);
    rd_chk("ref hi", PCSD_OFS_REF_HI, 32'h0000000f);
    rd_chk("ref lo", PCSD_OFS_REF_LO, 32'h000000ff);
    rd_chk("control", PCSD_OFS_CTL, 32'h00000000);
  endtask

  // Counts enables over n cycles and flags ticks that stray from the module enable.
  task automatic count_en(input int n, output int cs, output int cb, output int cm);
    logic bad;
    cs = 0;
    cb = 0;
    cm = 0;
    bad = 1'b0;
    repeat (n) begin
      @(negedge hclk);
      cs += (sys_clk_en === 1'b1);
      cb += (bus_clk_en === 1'b1);
      cm += (mod_clk_en === 1'b1);
      if ({baud_tick, timer_tick, rti_tick, cop_tick} !== {4{mod_clk_en}}) bad = 1'b1;
      if (bus_clk_en === 1'b1 && sys_clk_en !== 1'b1) bad = 1'b1;
    end
    check("tick copies and bus inside sys", 32'h0, {31'h0, bad});
    @(posedge hclk);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 8; i++) begin
      rows[i].ctl = 8'((i << 2) | (i % 4));
      rows[i].n_sys = 2048 >> i;
      rows[i].n_bus = 1024 >> i;
      rows[i].n_mod = (1024 >> i) >> (i % 4);
    end
    do_reset();
    chk_reset();
    wr(PCSD_OFS_LOOP_HI, 32'hffffffa5);
    rd_chk("loop hi width", PCSD_OFS_LOOP_HI, 32'h00000005);
    wr(PCSD_OFS_REF_LO, 32'h0000013c);
    rd_chk("ref lo width", PCSD_OFS_REF_LO, 32'h0000003c);
    wr(8'h14, 32'h000000ff);
    rd_chk("unmapped", 8'h14, 32'h00000000);
    // Select without a running loop is stored but must leave the crystal as root; the flag write is ignored.
    wr(PCSD_OFS_CTL, 32'h000000a0);
    rd_chk("flag not writable", PCSD_OFS_CTL, 32'h00000020);
    repeat (50) @(posedge hclk);
    check("no lock no loop root", 32'h0, {31'h0, root_is_loop});
    for (int i = 0; i < 8; i++) begin
      wr(PCSD_OFS_CTL, {24'h0, rows[i].ctl});
      rd_chk("both selects", PCSD_OFS_CTL, {24'h0, rows[i].ctl});
      repeat (4096) @(posedge hclk);
      count_en(2048, s, b, m);
      check("sys count", rows[i].n_sys, s);
      check("bus count", rows[i].n_bus, b);
      check("mod count", rows[i].n_mod, m);
    end
    // Loop at half the crystal rate: reference 8, loop 4.
    wr(PCSD_OFS_REF_HI, 32'h0);
    wr(PCSD_OFS_REF_LO, 32'h8);
    wr(PCSD_OFS_LOOP_HI, 32'h0);
    wr(PCSD_OFS_LOOP_LO, 32'h4);
    wr(PCSD_OFS_CTL, 32'h00000040);
    @(posedge hclk);
    check("loop on", 32'h1, {31'h0, loop_running});
    k = 0;
    do begin
      xfer(1'b0, PCSD_OFS_CTL, 32'h0, rd);
      k++;
    end while (rd[7] !== 1'b1 && k < 500);
    check("lock flag", 32'h1, {31'h0, rd[7]});
    check("locked not selected", 32'h0, {31'h0, root_is_loop});
    wr(PCSD_OFS_CTL, 32'h00000060);
    repeat (200) @(posedge hclk);
    check("loop root", 32'h1, {31'h0, root_is_loop});
    count_en(1600, s, b, m);
    // A settled loop at four eighths of the crystal rate gives 800 system and 400 bus ticks.
    check("loop sys count", 32'h320, s);
    check("loop bus count", 32'h190, b);
    wait_mode <= 1'b1;
    stop_mode <= 1'b1;
    repeat (100) @(posedge hclk);
    check("loop runs in stop", 32'h1, {31'h0, loop_running});
    check("root kept in stop", 32'h1, {31'h0, root_is_loop});
    count_en(64, s, b, m);
    check("clock alive in stop", 32'h1, {31'h0, s > 0});
    wait_mode <= 1'b0;
    stop_mode <= 1'b0;
    wr(PCSD_OFS_CTL, 32'h00000020);
    repeat (20) @(posedge hclk);
    check("loop off", 32'h0, {31'h0, loop_running});
    check("root back to crystal", 32'h0, {31'h0, root_is_loop});
    rd_chk("flag clear when off", PCSD_OFS_CTL, 32'h00000020);
    // Software now enters stop with the loop off; an unselected loop stays halted there.
    stop_mode <= 1'b1;
    wr(PCSD_OFS_CTL, 32'h00000040);
    @(posedge hclk);
    check("unselected loop halts in stop", 32'h0, {31'h0, loop_running});
    stop_mode <= 1'b0;
    @(posedge hclk);
    check("loop resumes after stop", 32'h1, {31'h0, loop_running});
    // A reset in mid-run must restore every default.
    wr(PCSD_OFS_CTL, 32'h0000001f);
    wr(PCSD_OFS_LOOP_LO, 32'h00000012);
    do_reset();
    chk_reset();
    summarize();
  end
endmodule
